// ### common/jls_pkg.sv
package jls_pkg;
  // ==========================================================
  // Device register map (10-bit register address, 8-bit data)
  localparam logic [9:0] OFF_DECIMATION   = 10'h140;
  localparam logic [9:0] OFF_NCO_PHASE_LO = 10'h143;
  localparam logic [9:0] OFF_NCO_PHASE_HI = 10'h145;
  localparam logic [9:0] OFF_SYNC_CTRL    = 10'h1e8;
  localparam logic [9:0] OFF_CAPTURE_WIN  = 10'h1ea;
  localparam logic [9:0] OFF_PREEMPHASIS  = 10'h1ef;
  localparam logic [9:0] OFF_SYNTH_SAMPLE = 10'h2bb;
  localparam logic [9:0] OFF_PLL_STATUS   = 10'h2dc;

  // ==========================================================
  // Field positions and reset values
  localparam int SYNC_ENABLE_BIT  = 1;
  localparam int SYNC_ONESHOT_BIT = 2;
  localparam int SYNC_NCO_BIT     = 5;
  localparam int SYNTH_REFCAP_BIT = 3;
  localparam int PLL_LOCK_BIT     = 0;
  localparam int PLL_ALIGNED_BIT  = 1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // Rates: IQ rate in 0.1 MSPS units, line rate in Mbps
  localparam logic [15:0] IQ_ONE_MIN     = 16'd768;
  localparam logic [15:0] IQ_ONE_MAX     = 16'd1333;
  localparam logic [15:0] IQ_TWO_MIN     = 16'd1536;
  localparam logic [15:0] IQ_TWO_MAX     = 16'd2667;
  localparam logic [15:0] LINE_MIN_MBPS  = 16'd3072;
  localparam logic [15:0] LINE_MAX_MBPS  = 16'd5333;
  localparam int          LINE_FACTOR    = 40;
  localparam int          IQ_UNIT_DIV    = 10;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ          = 125;
  localparam int PLL_LOCK_NS      = 1000;
  localparam int PLL_LOCK_CYCLES  = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int SYSREF_MIN_HIGH  = 2;
  localparam int SREF_HIGH_CYCLES = 4;
  localparam int SREF_PERIOD      = 64;

  // ==========================================================
  // Controller registers on AXI4-Lite
  localparam logic [3:0] OFF_HOST_CMD    = 4'h0;
  localparam logic [3:0] OFF_HOST_STATUS = 4'h4;
  localparam logic [3:0] OFF_HOST_SYSREF = 4'h8;
  localparam int CMD_READ_BIT  = 31;
  localparam int STAT_BUSY_BIT = 31;
  localparam int SREF_CONT_BIT = 8;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### common/jls_link_if.sv
interface jls_link_if;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       reg_ack;
  logic       sysref;
  logic       lane_a_en;
  logic       lane_b_en;

  modport dev (
    input  reg_addr, reg_wdata, reg_wr, reg_rd, sysref,
    output reg_rdata, reg_ack, lane_a_en, lane_b_en
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, sysref,
    input  reg_rdata, reg_ack, lane_a_en, lane_b_en
  );
endinterface

// ### core/jls_device.sv
// Contract
// R01: Preemphasis level set by a register
// R02: Preemphasis off after reset
// R03: Serializer clock equals lane line rate
// R04: PLL setup derived from IQ rate, lanes
// R05: Read-only serializer lock flag
// R06: Line rate kept within supported range
// R07: One lane low rates, two lanes high
// R08: Line rate is 40 times IQ over lanes
// R09: IQ rate is ADC rate over decimation
// R10: SYSREF aligns dividers and PHASE_ACCUMULATOR_OSCILLATOR reference
// R11: First alignment uncertain by one ADC cycle
// R12: Phase held once SYSREF sampled
// R13: SYSREF high at least two clock periods
// R14: Software clears bit 3 before synchronizing
// R15: Synth mode: reference edge, then resample
// R16: One-shot acts on second pulse only
// R17: Source sends at least two pulses
// R18: Captured SYSREF loads PHASE_ACCUMULATOR_OSCILLATOR initial phase
// R19: Second pulse resets dividers and PHASE_ACCUMULATOR_OSCILLATOR
// R20: Capture window tolerates SYSREF drift
//
// Register access over AXI4-Lite was left to the implementer.
module jls_device #(
  parameter int LMFC_CYCLES = 32
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  jls_link_if.dev          link,
  input  wire logic [15:0] adc_rate_100k,
  input  wire logic        synth_enable,
  input  wire logic        ref_clk_en,
  input  wire logic [7:0]  nco_step,
  output logic [15:0]      line_rate_mbps,
  output logic [1:0]       lanes_used,
  output logic             serializer_lock_flag,
  output logic [7:0]       preemph_level,
  output logic [7:0]       link_div_count,
  output logic             link_resync,
  output logic             sysref_aligned,
  output logic [15:0]      nco_phase
);
  import jls_pkg::*;

  generate
    if (LMFC_CYCLES < 4 || LMFC_CYCLES > 256) begin : g_bad_lmfc
      $error("LMFC_CYCLES must lie in 4..256");
    end
  endgenerate

  typedef struct packed {
    logic [7:0]  dec;
    logic [7:0]  nco_lo;
    logic [7:0]  nco_hi;
    logic [7:0]  sync;
    logic [7:0]  win;
    logic [7:0]  preemph;
    logic [7:0]  synth;
    logic [7:0]  rdata;
    logic        ack;
    logic        sref_s1;
    logic        sref_s2;
    logic        sref_ref;
    logic        sref_q;
    logic [1:0]  hi_cnt;
    logic [1:0]  pulse_cnt;
    logic        done;
    logic        aligned;
    logic        resync;
    logic [7:0]  div_cnt;
    logic [7:0]  nco_coarse;
    logic [7:0]  nco_fine;
    logic [23:0] cfg;
    logic [7:0]  lock_cnt;
    logic        locked;
    logic [15:0] line_rate;
    logic [1:0]  lanes;
  } jls_dev_state_t;

  jls_dev_state_t s_reg;
  jls_dev_state_t s_next;

  // ==========================================================
  // Rate arithmetic
  logic [15:0] iq_rate;
  logic [1:0]  lanes_calc;
  logic [31:0] line_calc;
  logic        rate_ok;

  always_comb begin
    iq_rate = (s_reg.dec == 8'h00) ? 16'h0000
            : 16'(adc_rate_100k / {8'h00, s_reg.dec}); // R09
    if (iq_rate >= IQ_ONE_MIN && iq_rate <= IQ_ONE_MAX) begin // R07
      lanes_calc = 2'd1;
    end else if (iq_rate >= IQ_TWO_MIN && iq_rate <= IQ_TWO_MAX) begin
      lanes_calc = 2'd2;
    end else begin
      lanes_calc = 2'd0;
    end
    line_calc = (lanes_calc == 2'd0) ? 32'h0000_0000
              : (32'(LINE_FACTOR) * {16'h0000, iq_rate})
                / (32'(IQ_UNIT_DIV) * {30'h0, lanes_calc}); // R08
    rate_ok = lanes_calc != 2'd0 && line_calc >= {16'h0, LINE_MIN_MBPS}
              && line_calc <= {16'h0, LINE_MAX_MBPS}; // R06
  end

  // ==========================================================
  // Next-state logic
  logic       event_seen;
  logic       act;
  logic       in_window;
  logic [8:0] d_off;
  logic [8:0] early_lim;
  logic [15:0] nco_sum;

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.resync = 1'b0;

    // Register port
    if (link.reg_wr) begin
      s_next.ack = 1'b1;
      unique case (link.reg_addr)
        OFF_DECIMATION:   s_next.dec = link.reg_wdata;
        OFF_NCO_PHASE_LO: s_next.nco_lo = link.reg_wdata;
        OFF_NCO_PHASE_HI: s_next.nco_hi = link.reg_wdata;
        OFF_SYNC_CTRL: begin
          s_next.sync = link.reg_wdata;
          s_next.pulse_cnt = 2'd0; // Rewrite rearms the one-shot
          s_next.done = 1'b0;
        end
        OFF_CAPTURE_WIN:  s_next.win = link.reg_wdata;
        OFF_PREEMPHASIS:  s_next.preemph = link.reg_wdata; // R01
        OFF_SYNTH_SAMPLE: s_next.synth = link.reg_wdata;
        default: ; // Status and unmapped writes are dropped
      endcase
    end else if (link.reg_rd) begin
      s_next.ack = 1'b1;
      unique case (link.reg_addr)
        OFF_DECIMATION:   s_next.rdata = s_reg.dec;
        OFF_NCO_PHASE_LO: s_next.rdata = s_reg.nco_lo;
        OFF_NCO_PHASE_HI: s_next.rdata = s_reg.nco_hi;
        OFF_SYNC_CTRL:    s_next.rdata = s_reg.sync;
        OFF_CAPTURE_WIN:  s_next.rdata = s_reg.win;
        OFF_PREEMPHASIS:  s_next.rdata = s_reg.preemph;
        OFF_SYNTH_SAMPLE: s_next.rdata = s_reg.synth;
        OFF_PLL_STATUS: begin
          s_next.rdata = 8'h00;
          s_next.rdata[PLL_LOCK_BIT] = s_reg.locked; // R05
          s_next.rdata[PLL_ALIGNED_BIT] = s_reg.aligned;
        end
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Serializer PLL: relock after every configuration change
    s_next.cfg = {adc_rate_100k, s_reg.dec};
    s_next.lanes = rate_ok ? lanes_calc : 2'd0; // R04
    s_next.line_rate = rate_ok ? line_calc[15:0] : 16'h0000; // R03
    if (s_next.cfg != s_reg.cfg || !rate_ok) begin // R04
      s_next.lock_cnt = 8'h00;
      s_next.locked = 1'b0;
    end else if (s_reg.lock_cnt == 8'(PLL_LOCK_CYCLES - 1)) begin
      s_next.locked = 1'b1; // R05
    end else begin
      s_next.lock_cnt = s_reg.lock_cnt + 8'h01;
    end

    // SYSREF path: only the second stage is read
    s_next.sref_s1 = link.sysref;
    s_next.sref_s2 = s_reg.sref_s1;
    if (ref_clk_en) begin
      s_next.sref_ref = s_reg.sref_s2; // R15
    end
    s_next.sref_q = (synth_enable && !s_reg.synth[SYNTH_REFCAP_BIT])
                  ? s_reg.sref_ref : s_reg.sref_s2; // R15

    // Highs of sref_q shorter than two cycles never count as a pulse
    if (!s_reg.sref_q) begin
      s_next.hi_cnt = 2'd0;
    end else if (s_reg.hi_cnt < 2'(SYSREF_MIN_HIGH)) begin
      s_next.hi_cnt = s_reg.hi_cnt + 2'd1;
    end
    event_seen = s_reg.sref_q
               && s_reg.hi_cnt == 2'(SYSREF_MIN_HIGH - 1); // R13

    // Window around the expected boundary, in cycles
    d_off = (s_reg.div_cnt == 8'(LMFC_CYCLES - 1)) ? 9'h000
          : {1'b0, s_reg.div_cnt} + 9'h001;
    early_lim = 9'(LMFC_CYCLES) - {5'h00, s_reg.win[3:0]};
    in_window = d_off <= {5'h00, s_reg.win[7:4]}
              || (s_reg.win[3:0] != 4'h0 && d_off >= early_lim); // R20

    act = 1'b0;
    if (event_seen && s_reg.sync[SYNC_ENABLE_BIT]) begin // R10
      if (s_reg.sync[SYNC_ONESHOT_BIT]) begin
        if (!s_reg.done) begin
          s_next.pulse_cnt = s_reg.pulse_cnt + 2'd1;
          if (s_reg.pulse_cnt == 2'd1) begin // R16
            act = 1'b1;
            s_next.done = 1'b1;
          end
        end
      end else begin
        act = !(s_reg.aligned && in_window); // R20
      end
    end

    // Free-running divider keeps the captured phase
    if (act) begin
      s_next.div_cnt = 8'h00; // R19
      s_next.aligned = 1'b1; // R11
      s_next.resync = 1'b1;
    end else if (s_reg.div_cnt == 8'(LMFC_CYCLES - 1)) begin
      s_next.div_cnt = 8'h00; // R12
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 8'h01;
    end

    nco_sum = {s_reg.nco_coarse, s_reg.nco_fine} + {8'h00, nco_step};
    if (act && s_reg.sync[SYNC_NCO_BIT]) begin
      s_next.nco_coarse = s_reg.nco_hi; // R18
      s_next.nco_fine = s_reg.nco_lo; // R19
    end else begin
      s_next.nco_coarse = nco_sum[15:8];
      s_next.nco_fine = nco_sum[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0; // R02
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign link.reg_rdata = s_reg.rdata;
  assign link.reg_ack = s_reg.ack;
  assign link.lane_a_en = s_reg.locked && s_reg.lanes != 2'd0;
  assign link.lane_b_en = s_reg.locked && s_reg.lanes == 2'd2; // R07
  assign line_rate_mbps = s_reg.line_rate;
  assign lanes_used = s_reg.lanes;
  assign serializer_lock_flag = s_reg.locked;
  assign preemph_level = s_reg.preemph;
  assign link_div_count = s_reg.div_cnt;
  assign link_resync = s_reg.resync;
  assign sysref_aligned = s_reg.aligned;
  assign nco_phase = {s_reg.nco_coarse, s_reg.nco_fine};
endmodule

// ### core/jls_host.sv
module jls_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  jls_link_if.host         link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import jls_pkg::*;

  typedef struct packed {
    logic        aw_have;
    logic [3:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        busy;
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdback;
    logic [7:0]  sref_left;
    logic        sref_cont;
    logic [6:0]  sref_phase;
    logic        sref_out;
  } jls_host_state_t;

  jls_host_state_t s_reg;
  jls_host_state_t s_next;

  logic       sref_run;
  logic [7:0] cnt_req;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.wr = 1'b0;
    s_next.rd = 1'b0;
    cnt_req = s_reg.w_data[7:0];

    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Both halves held: commit the write
    if (s_reg.aw_have && s_reg.w_have) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      unique case (s_reg.aw_addr)
        OFF_HOST_CMD: begin
          if (s_reg.busy) begin
            s_next.bresp = RESP_SLVERR; // One access at a time
          end else begin
            s_next.busy = 1'b1;
            s_next.addr = s_reg.w_data[17:8];
            s_next.wdata = s_reg.w_data[7:0];
            s_next.rd = s_reg.w_data[CMD_READ_BIT];
            s_next.wr = !s_reg.w_data[CMD_READ_BIT];
          end
        end
        OFF_HOST_SYSREF: begin
          s_next.sref_cont = s_reg.w_data[SREF_CONT_BIT];
          s_next.sref_left = (cnt_req != 8'h00 && cnt_req < 8'd2)
                           ? 8'd2 : cnt_req; // R17
          s_next.sref_phase = 7'h00;
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end

    if (s_reg.busy && link.reg_ack) begin
      s_next.busy = 1'b0;
      s_next.rdback = link.reg_rdata;
    end

    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end else if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_HOST_CMD: s_next.rdata = {14'h0000, s_reg.addr, s_reg.wdata};
        OFF_HOST_STATUS: begin
          s_next.rdata[STAT_BUSY_BIT] = s_reg.busy;
          s_next.rdata[9:8] = {link.lane_b_en, link.lane_a_en};
          s_next.rdata[7:0] = s_reg.rdback;
        end
        OFF_HOST_SYSREF:
          s_next.rdata = {23'h000000, s_reg.sref_cont, s_reg.sref_left};
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end

    // SYSREF pulses: fixed width, fixed period
    sref_run = s_reg.sref_cont || s_reg.sref_left != 8'h00;
    s_next.sref_out = sref_run
                    && s_reg.sref_phase < 7'(SREF_HIGH_CYCLES); // R13
    if (sref_run) begin
      if (s_reg.sref_phase == 7'(SREF_PERIOD - 1)) begin
        s_next.sref_phase = 7'h00;
        if (!s_reg.sref_cont) begin
          s_next.sref_left = s_reg.sref_left - 8'h01;
        end
      end else begin
        s_next.sref_phase = s_reg.sref_phase + 7'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !s_reg.aw_have && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_have && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign link.reg_addr = s_reg.addr;
  assign link.reg_wdata = s_reg.wdata;
  assign link.reg_wr = s_reg.wr;
  assign link.reg_rd = s_reg.rd;
  assign link.sysref = s_reg.sref_out;
endmodule

// ### tb/jls_link_properties.sv
module jls_link_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  input wire logic       sysref,
  input wire logic       lane_a_en,
  input wire logic       lane_b_en
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Register port handshake
  sequence s_strobe;
    reg_wr || reg_rd;
  endsequence

  property p_ack_follows;
    s_strobe |=> reg_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("no ack one cycle after a strobe");

  property p_ack_cause;
    reg_ack |-> $past(reg_wr || reg_rd);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a strobe before it");

  property p_ack_single;
    reg_ack |=> !reg_ack;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack longer than one cycle");

  property p_strobe_excl;
    !(reg_wr && reg_rd);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("read and write strobe together");

  // Host must wait for the ack, so strobes never sit back to back
  property p_strobe_gap;
    s_strobe |=> !(reg_wr || reg_rd);
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("strobe in the cycle after a strobe");

  property p_rdata_hold;
    $changed(reg_rdata) |-> reg_ack && $past(reg_rd);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside a read answer");

  // ==========================================================
  // Lanes and SYSREF pulses
  property p_two_lanes;
    lane_b_en |-> lane_a_en;
  endproperty
  a_two_lanes: assert property (p_two_lanes)
    else $error("second lane active without the first");

  sequence s_pulse;
    sysref [*4] ##1 !sysref;
  endsequence

  property p_sref_width;
    $rose(sysref) |-> s_pulse;
  endproperty
  a_sref_width: assert property (p_sref_width)
    else $error("sysref pulse not four cycles wide");

  property p_sref_gap;
    $fell(sysref) |-> !sysref [*8];
  endproperty
  a_sref_gap: assert property (p_sref_gap)
    else $error("sysref pulses too close together");
endmodule

// ### tb/jls_link_setup_sysref_sync_tb.sv
module jls_link_setup_sysref_sync_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import jls_pkg::*;

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("wrong value at %0t: got %h expected %h", \
  $time, g, e); end end

  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        synth_en, lock, resync, aligned;
  logic        ref_en = 1'b0;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp, lanes;
  logic [1:0]  ref_ph = 2'b00;
  logic [15:0] adc_rate, line_rate, nco_phase;
  logic [7:0]  nco_step, preemph, div_cnt, b;
  int          fails, samples_checked, resync_cnt, iq, nl, n0;
  localparam logic [9:0] OFFS [8] = '{OFF_DECIMATION, OFF_NCO_PHASE_LO,
    OFF_NCO_PHASE_HI, OFF_SYNC_CTRL, OFF_CAPTURE_WIN, OFF_PREEMPHASIS,
    OFF_SYNTH_SAMPLE, OFF_PLL_STATUS};
  localparam logic [7:0] DECS [6] = '{8'h10, 8'h18, 8'h11, 8'h0c, 8'h00,
    8'h20};
  localparam logic [7:0] MODES [3] = '{8'h26, 8'h06, 8'h06};

  jls_link_if link_bus ();

  jls_host i_jls_host (.aclk(aclk), .aresetn(aresetn), .link(link_bus),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Short frame count keeps the divider wrap visible in a short run
  jls_device #(.LMFC_CYCLES(8)) i_jls_device (.aclk(aclk),
    .aresetn(aresetn), .link(link_bus), .adc_rate_100k(adc_rate),
    .synth_enable(synth_en), .ref_clk_en(ref_en), .nco_step(nco_step),
    .line_rate_mbps(line_rate), .lanes_used(lanes),
    .serializer_lock_flag(lock), .preemph_level(preemph),
    .link_div_count(div_cnt), .link_resync(resync),
    .sysref_aligned(aligned), .nco_phase(nco_phase));

  jls_link_properties u_props (.aclk(aclk), .aresetn(aresetn),
    .reg_wr(link_bus.reg_wr), .reg_rd(link_bus.reg_rd),
    .reg_rdata(link_bus.reg_rdata), .reg_ack(link_bus.reg_ack),
    .sysref(link_bus.sysref), .lane_a_en(link_bus.lane_a_en),
    .lane_b_en(link_bus.lane_b_en));

  // ==========================================================
  // Clock, reference edge and monitors
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    ref_ph <= ref_ph + 2'd1;
    ref_en <= (ref_ph == 2'd3);
    if (resync === 1'b1) resync_cnt <= resync_cnt + 1;
    if (resync === 1'b1) `CHK(div_cnt, 8'h00)
    if (aresetn) `CHK(div_cnt < 8'd8, 1'b1)
  end

  // ==========================================================
  // Bus tasks
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    bit awd, wd, awh, wh;
    awd = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awd && wd)) begin
      @(negedge aclk);
      awh = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      if (awh) begin
        awvalid <= 1'b0;
        awd = 1;
      end
      if (wh) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Status is polled since the link transfer outlasts the bus answer
  task automatic dev_op(input logic rnw, input logic [9:0] a,
                        input logic [7:0] d);
    axi_wr(OFF_HOST_CMD, {rnw, 13'h0, a, d});
    do axi_rd(OFF_HOST_STATUS); while (rd[STAT_BUSY_BIT] !== 1'b0);
    b = rd[7:0];
  endtask

  task give_verdict;
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    give_verdict();
  end

  // ==========================================================
  // Tests
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, synth_en, nco_step} = '0;
    {fails, samples_checked} = '0;
    wstrb = 4'hf;
    adc_rate = 16'd24576;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      dev_op(1'b1, OFFS[i], 8'h00);
      `CHK(b, REG_RESET)
    end
    for (int i = 0; i < 7; i++) dev_op(1'b0, OFFS[i], 8'h50 + 8'(i));
    for (int i = 0; i < 7; i++) begin
      dev_op(1'b1, OFFS[i], 8'h00);
      `CHK(b, 8'h50 + 8'(i))
    end
    `CHK(preemph, 8'h55)
    dev_op(1'b0, OFF_PLL_STATUS, 8'hff);
    dev_op(1'b1, OFF_PLL_STATUS, 8'h00);
    `CHK(b, 8'h00)
    for (int i = 3; i < 7; i++) dev_op(1'b0, OFFS[i], 8'h00);
    axi_wr(4'hc, 32'h0);
    `CHK(rsp, RESP_SLVERR)
    axi_rd(4'hc);
    `CHK(rsp, RESP_SLVERR)
    `CHK(rd, 32'h0)
    for (int i = 0; i < 6; i++) begin
      dev_op(1'b0, OFF_DECIMATION, DECS[i]);
      iq = (DECS[i] == 0) ? 0 : 24576 / DECS[i];
      nl = (iq >= 768 && iq <= 1333) ? 1 :
           (iq >= 1536 && iq <= 2667) ? 2 : 0;
      repeat (140) @(posedge aclk);
      `CHK(lanes, 2'(nl))
      if (nl != 0) `CHK(line_rate, 16'(iq * 4 / nl))
      `CHK(lock, 1'(nl != 0))
      dev_op(1'b1, OFF_PLL_STATUS, 8'h00);
      `CHK(b[PLL_LOCK_BIT], 1'(nl != 0))
      axi_rd(OFF_HOST_STATUS);
      `CHK(rd[9:8], (nl == 2) ? 2'b11 : 2'(nl))
    end
    dev_op(1'b0, OFF_NCO_PHASE_LO, 8'h12);
    dev_op(1'b0, OFF_NCO_PHASE_HI, 8'h34);
    for (int k = 0; k < 3; k++) begin
      // Five steps move the phase, so only a reload can bring it back
      nco_step <= 8'h01;
      repeat (5) @(posedge aclk);
      nco_step <= 8'h00;
      synth_en <= (k == 2);
      dev_op(1'b0, OFF_SYNC_CTRL, MODES[k]);
      n0 = resync_cnt;
      axi_wr(OFF_HOST_SYSREF, 32'h3);
      repeat (40) @(posedge aclk);
      `CHK(resync_cnt, n0)
      repeat (200) @(posedge aclk);
      `CHK(resync_cnt, n0 + 1)
      `CHK(aligned, 1'b1)
      `CHK(nco_phase, 16'h3412 + 16'(5 * k))
    end
    // Continuous capture: at most one realignment, then the window holds
    dev_op(1'b0, OFF_CAPTURE_WIN, 8'h21);
    dev_op(1'b0, OFF_SYNC_CTRL, 8'h02);
    n0 = resync_cnt;
    axi_wr(OFF_HOST_SYSREF, 32'h100);
    axi_rd(OFF_HOST_SYSREF);
    `CHK(rd, 32'h0000_0100)
    repeat (100) @(posedge aclk);
    `CHK(resync_cnt - n0 <= 1, 1'b1)
    n0 = resync_cnt;
    repeat (300) @(posedge aclk);
    `CHK(resync_cnt, n0)
    `CHK(aligned, 1'b1)
    give_verdict();
  end
endmodule
